// File: rtl/dac_frame_pkg.sv
package dac_frame_pkg;

   // ==========================================================
   // frame layout
   // ==========================================================
   localparam int FRAME_BITS = 16;
   localparam int CODE_BITS  = 12;
   localparam int NUM_CH     = 4;
   localparam logic [4:0] LAST_BIT_IDX = 5'd15; // index of the sixteenth bit
   localparam logic [4:0] FRAME_DONE   = 5'd16; // counter parks here

   typedef struct packed {
      logic [1:0]           chan; // channel, or termination in power-down
      logic [1:0]           mode;
      logic [CODE_BITS-1:0] code;
   } frame_t;

   // ==========================================================
   // mode and termination encodings
   // ==========================================================
   localparam logic [1:0] MODE_WRITE_ONLY   = 2'h0;
   localparam logic [1:0] MODE_WRITE_UPDATE = 2'h1;
   localparam logic [1:0] MODE_UPDATE_ALL   = 2'h2;
   localparam logic [1:0] MODE_POWER_DOWN   = 2'h3;

   localparam logic [1:0] TERM_1K   = 2'h0;
   localparam logic [1:0] TERM_100K = 2'h1;
   localparam logic [1:0] TERM_HIZ  = 2'h2;

   typedef struct packed {
      logic       active;
      logic [1:0] term;
   } pd_state_t;

   // ==========================================================
   // register map (byte offsets)
   // ==========================================================
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CODE0  = 8'h08; // outputs, +4 per channel
   localparam logic [7:0] OFS_HOLD0  = 8'h18; // holding regs, +4 per channel
   localparam logic [7:0] OFS_LAST   = 8'h28;
   localparam logic [7:0] OFS_STEP   = 8'h04;

   localparam int CTRL_ACCEPT_BIT = 0;
   localparam int CTRL_ZERO_BIT   = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;

   localparam int STAT_CNT_W     = 16;
   localparam int STAT_PD_BIT    = 16;
   localparam int STAT_TERM_LSB  = 17;
   localparam int STAT_SEEN_BIT  = 19;
   localparam int STAT_LINK_BIT  = 20;
   localparam int STAT_DROP_LSB  = 24;
   localparam int STAT_DROP_W    = 8;

endpackage : dac_frame_pkg

// File: rtl/bit_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// two-flop level synchroniser
// ==========================================================
module bit_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule // bit_sync

`default_nettype wire

// File: rtl/frame_capture.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// link side: shifts the frame on falling shift clock edges
// ==========================================================
module frame_capture
   import dac_frame_pkg::*;
(
   input  wire logic                  sclk,
   input  wire logic                  sync_n,
   input  wire logic                  sdin,
   input  wire logic                  rst_n,
   output logic      [FRAME_BITS-1:0] word_r,
   output logic                       done_tgl_r
);

   logic [4:0]            count_r;
   logic [FRAME_BITS-2:0] shift_r;

   // frame sync high clears the count at once: a short frame is gone
   // and the shift clock may stop without stranding state
   always_ff @(negedge sclk or posedge sync_n or negedge rst_n) begin
      if (!rst_n || sync_n) begin
         count_r <= '0;
      end else if (count_r != FRAME_DONE) begin
         count_r <= count_r + 5'd1;
      end // parked at 16 until sync rises
   end

   // data taken on the falling edge only while sync is low
   always_ff @(negedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r <= '0;
      end else if (!sync_n && count_r < LAST_BIT_IDX) begin
         shift_r <= {shift_r[FRAME_BITS-3:0], sdin};
      end
   end

   // sixteenth edge: publish the word and flip the event toggle on that same edge
   always_ff @(negedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         word_r     <= '0;
         done_tgl_r <= 1'b0;
      end else if (!sync_n && count_r == LAST_BIT_IDX) begin
         word_r     <= {shift_r, sdin};
         done_tgl_r <= ~done_tgl_r;
      end
   end

endmodule // frame_capture

`default_nettype wire

// File: rtl/quad_dac_frame_ctrl.sv
// Overview of operation
// - one sixteen-bit shift register holds channel, mode, power-down and code.
// - two mode bits choose simultaneous update of all or one channel.
// - after sync falls, data sampled on each falling shift clock edge.
// - shift register enabled only while frame sync is low.
// - frame applied on the sixteenth clock; host holds sync low throughout.
// - sync rising before sixteen clocks aborts; nothing changes.
// - outputs are zero from power-on until the first complete frame.
// - frame can select power-down with three output termination choices.
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module quad_dac_frame_ctrl
   import dac_frame_pkg::*;
(
   input  wire logic                              hclk,
   input  wire logic                              hresetn,
   // ahb-lite slave
   input  wire logic                              hsel,
   input  wire logic [31:0]                       haddr,
   input  wire logic [1:0]                        htrans,
   input  wire logic                              hwrite,
   input  wire logic [2:0]                        hsize,
   input  wire logic [31:0]                       hwdata,
   input  wire logic                              hready,
   output logic                                   hreadyout,
   output logic                                   hresp,
   output logic      [31:0]                       hrdata,
   // serial link
   input  wire logic                              sclk,
   input  wire logic                              sync_n,
   input  wire logic                              sdin,
   // converter side
   output logic      [NUM_CH-1:0][CODE_BITS-1:0]  out_code,
   output logic                                   pd_active,
   output logic      [1:0]                        pd_term
);

   // ==========================================================
   // declarations
   // ==========================================================
   // link-domain state lives in the capture block
   typedef enum logic [1:0] {ST_IDLE, ST_APPLY, ST_ZERO} apply_st_t;

   apply_st_t                        st_r;
   apply_st_t                        st_nxt;
   logic [FRAME_BITS-1:0]            link_word;
   logic                             link_tgl;
   logic [1:0]                       sync_q;
   logic                             tgl_seen_r;
   logic                             frame_evt;
   frame_t                           frame_r;
   logic [NUM_CH-1:0][CODE_BITS-1:0] hold_r;
   logic [NUM_CH-1:0][CODE_BITS-1:0] code_r;
   pd_state_t                        pd_r;
   logic                             accept_en_r;
   logic                             zero_req_r;
   logic [STAT_CNT_W-1:0]            frame_cnt_r;
   logic [STAT_DROP_W-1:0]           drop_cnt_r;
   logic                             seen_r;
   logic                             wr_pend_r;
   logic [7:0]                       wr_addr_r;
   logic                             addr_ok;
   logic [31:0]                      rd_mux;
   logic [7:0]                       rd_ofs;

   // ==========================================================
   // link domain and crossing
   // ==========================================================
   // link logic shares the bus reset
   frame_capture u_capture (
      .sclk       (sclk),
      .sync_n     (sync_n),
      .sdin       (sdin),
      .rst_n      (hresetn),
      .word_r     (link_word),
      .done_tgl_r (link_tgl)
   );

   // toggle and sync level into the bus clock domain
   // a toggle, not a pulse: a pulse may fall
   // between two bus clock edges
   bit_sync #(.W(2)) u_sync (
      .clk   (hclk),
      .rst_n (hresetn),
      .d     ({~sync_n, link_tgl}),
      .q     (sync_q)
   );

   // edge of the synchronised toggle marks one finished frame
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tgl_seen_r <= 1'b0;
      end else begin
         tgl_seen_r <= sync_q[0];
      end
   end

   assign frame_evt = sync_q[0] ^ tgl_seen_r;

   // ==========================================================
   // apply sequencer
   // ==========================================================
   // word_r is stable here: the link needs sixteen more shift
   // clocks before it can change it again
   // frames dropped while disabled leave it alone
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_r <= '0;
      end else if (frame_evt && accept_en_r) begin
         frame_r <= frame_t'(link_word);
      end
   end

   // a frame event wins over a pending zero request
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         ST_IDLE: begin
            if (frame_evt && accept_en_r) begin
               st_nxt = ST_APPLY;
            end else if (zero_req_r) begin
               st_nxt = ST_ZERO;
            end
         end
         ST_APPLY: begin
            // a frame landing now is taken next
            if (frame_evt && accept_en_r) begin
               st_nxt = ST_APPLY;
            end else begin
               st_nxt = ST_IDLE;
            end
         end
         ST_ZERO: begin
            // request clears now: only a frame counts
            if (frame_evt && accept_en_r) begin
               st_nxt = ST_APPLY;
            end else begin
               st_nxt = ST_IDLE;
            end
         end
         default: begin
            st_nxt = ST_IDLE; // unused code
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // holding and output codes
   // ==========================================================
   // every mode but power-down loads the addressed holding reg
   // (power-down frames carry a termination)
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_r <= '0;
      end else if (st_r == ST_ZERO) begin
         hold_r <= '0;
      end else if (st_r == ST_APPLY && frame_r.mode != MODE_POWER_DOWN) begin
         hold_r[frame_r.chan] <= frame_r.code;
      end
   end

   // outputs start at zero and stay there until a frame updates them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         code_r <= '0;
      end else if (st_r == ST_ZERO) begin
         code_r <= '0;
      end else if (st_r == ST_APPLY) begin
         unique case (frame_r.mode)
            MODE_WRITE_UPDATE: begin
               code_r[frame_r.chan] <= frame_r.code;
            end
            MODE_UPDATE_ALL: begin
               // all four move on the same edge
               for (int i = 0; i < NUM_CH; i++) begin
                  code_r[i] <= (i == int'(frame_r.chan)) ? frame_r.code : hold_r[i];
               end
            end
            default: begin
               // write-only and power-down
               code_r <= code_r;
            end
         endcase
      end
   end

   // ==========================================================
   // power-down
   // ==========================================================
   // channel field picks termination; any updating frame wakes up
   // codes and holdings are left alone here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pd_r <= '0;
      end else if (st_r == ST_APPLY) begin
         unique case (frame_r.mode)
            MODE_POWER_DOWN: begin
               pd_r.active <= 1'b1;
               // both upper codes pick the open output
               pd_r.term   <= (frame_r.chan == TERM_1K)   ? TERM_1K :
                              (frame_r.chan == TERM_100K) ? TERM_100K : TERM_HIZ;
            end
            MODE_WRITE_UPDATE, MODE_UPDATE_ALL: begin
               pd_r <= '0;
            end
            default: begin
               pd_r <= pd_r;
            end
         endcase
      end
   end

   // ==========================================================
   // statistics
   // ==========================================================
   // counts wrap; a dropped frame is one finished while disabled
   // eight drop bits: software must read often
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_cnt_r <= '0;
         drop_cnt_r  <= '0;
         seen_r      <= 1'b0;
      end else if (frame_evt) begin
         if (accept_en_r) begin
            frame_cnt_r <= frame_cnt_r + 16'h0001;
            seen_r      <= 1'b1;
         end else begin
            drop_cnt_r <= drop_cnt_r + 8'h01;
         end
      end
   end

   // ==========================================================
   // ahb-lite slave
   // ==========================================================
   assign addr_ok = hsel && htrans[1] && hready;

   // writes land in the data phase; zero-wait, always okay
   // hsize ignored: word access only
   // a read in a write's data phase sees old data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend_r <= addr_ok && hwrite;
         wr_addr_r <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // control: accept enable and a self-clearing zero request
   // accept off drops frames but still counts them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         accept_en_r <= CTRL_RESET[CTRL_ACCEPT_BIT];
         zero_req_r  <= CTRL_RESET[CTRL_ZERO_BIT];
      end else begin
         if (wr_pend_r && wr_addr_r == OFS_CTRL) begin
            accept_en_r <= hwdata[CTRL_ACCEPT_BIT];
         end
         // new request wins over the clear by the sequencer
         if (wr_pend_r && wr_addr_r == OFS_CTRL && hwdata[CTRL_ZERO_BIT]) begin
            zero_req_r <= 1'b1;
         end else if (st_r == ST_ZERO) begin
            zero_req_r <= 1'b0;
         end
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rd_ofs = haddr[7:0];
      rd_mux = '0;
      if (rd_ofs == OFS_CTRL) begin
         rd_mux[CTRL_ACCEPT_BIT] = accept_en_r;
         rd_mux[CTRL_ZERO_BIT]   = zero_req_r;
      end else if (rd_ofs == OFS_STATUS) begin
         rd_mux[STAT_CNT_W-1:0]                      = frame_cnt_r;
         rd_mux[STAT_PD_BIT]                         = pd_r.active;
         rd_mux[STAT_TERM_LSB+1:STAT_TERM_LSB]       = pd_r.term;
         rd_mux[STAT_SEEN_BIT]                       = seen_r;
         rd_mux[STAT_LINK_BIT]                       = sync_q[1];
         rd_mux[STAT_DROP_LSB+STAT_DROP_W-1:STAT_DROP_LSB] = drop_cnt_r;
      end else if (rd_ofs == OFS_LAST) begin
         rd_mux[FRAME_BITS-1:0] = frame_r;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (rd_ofs == OFS_CODE0 + 8'(i) * OFS_STEP) begin
               rd_mux[CODE_BITS-1:0] = code_r[i];
            end
            if (rd_ofs == OFS_HOLD0 + 8'(i) * OFS_STEP) begin
               rd_mux[CODE_BITS-1:0] = hold_r[i];
            end
         end
      end
   end

   // read data registered at the address phase edge
   // and held until the next read is taken
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (addr_ok && !hwrite) begin
         hrdata <= rd_mux;
      end
   end

   // ==========================================================
   // converter outputs
   // ==========================================================
   // one more register so outputs come from flops of their own
   // costs one cycle of latency per update
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_code  <= '0;
         pd_active <= 1'b0;
         pd_term   <= TERM_1K;
      end else begin
         out_code  <= code_r;
         pd_active <= pd_r.active;
         pd_term   <= pd_r.term;
      end
   end

endmodule // quad_dac_frame_ctrl

`default_nettype wire

// File: testbench/quad_dac_sva.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// frame checker on the top ports
// ==========================================
module quad_dac_sva
   import dac_frame_pkg::*;
(
   input wire logic                             hclk,
   input wire logic                             hresetn,
   input wire logic                             hsel,
   input wire logic [31:0]                      haddr,
   input wire logic [1:0]                       htrans,
   input wire logic                             hwrite,
   input wire logic [31:0]                      hwdata,
   input wire logic                             hready,
   input wire logic                             hreadyout,
   input wire logic                             hresp,
   input wire logic                             sclk,
   input wire logic                             sync_n,
   input wire logic                             sdin,
   input wire logic [NUM_CH-1:0][CODE_BITS-1:0] out_code,
   input wire logic                             pd_active,
   input wire logic [1:0]                       pd_term
);
   logic [4:0]  cnt_r;
   logic [15:0] word_r;
   logic        tgl_r;
   logic [2:0]  tsy_r;
   logic        acc_r;
   logic        wr_r;
   logic        seen_r;
   logic [3:0]  quiet_r;
   logic [NUM_CH-1:0][CODE_BITS-1:0] hold_r;
   frame_t      fw;
   wire logic   fin = tsy_r[2] ^ tsy_r[1];
   assign fw = word_r;

   // own link view; sync high clears the count at once, mid-clock too
   always_ff @(negedge sclk or posedge sync_n or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= '0;
         word_r <= '0;
         tgl_r <= 1'b0;
      end else if (sync_n) begin
         cnt_r <= '0;
      end else if (cnt_r != FRAME_DONE) begin
         cnt_r <= cnt_r + 5'h1;
         word_r <= {word_r[14:0], sdin};
         if (cnt_r == LAST_BIT_IDX) begin
            tgl_r <= ~tgl_r;
         end
      end
   end

   // bus-side tracking; quiet counts cycles with no cause for change
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tsy_r <= '0;
         acc_r <= 1'b1;
         wr_r <= 1'b0;
         seen_r <= 1'b0;
         quiet_r <= '0;
         hold_r <= '0;
      end else begin
         tsy_r <= {tsy_r[1:0], tgl_r};
         wr_r <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == OFS_CTRL;
         if (wr_r) begin
            acc_r <= hwdata[CTRL_ACCEPT_BIT];
         end
         if (fin && acc_r) begin
            seen_r <= 1'b1;
         end
         if (fin && acc_r && fw.mode != MODE_POWER_DOWN) begin
            hold_r[fw.chan] <= fw.code;
         end
         if (wr_r && hwdata[CTRL_ZERO_BIT]) begin
            hold_r <= '0;
         end
         if (fin || wr_r) begin
            quiet_r <= '0;
         end else if (quiet_r != 4'hf) begin
            quiet_r <= quiet_r + 4'h1;
         end
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_end(logic [1:0] m);
      fin && acc_r && fw.mode == m;
   endsequence

   AST_BUS_OKAY: assert property (!hresp && hreadyout)
      else $error("bus answer not ready or not okay");
   AST_ZERO_UNTIL_FRAME: assert property (
      !seen_r |-> out_code == '0 && !pd_active) else $error("output left zero early");
   AST_QUIET_STABLE: assert property (
      quiet_r > 4'h9 |-> $stable(out_code) && $stable(pd_active))
      else $error("outputs moved without a frame");
   AST_ONE_CHANNEL: assert property (
      s_end(MODE_WRITE_UPDATE) |-> ##[1:6] (out_code[fw.chan] == fw.code && !pd_active))
      else $error("single channel update missing");
   AST_ALL_CHANNELS: assert property (
      s_end(MODE_UPDATE_ALL) |-> ##[1:6] (out_code == hold_r && !pd_active))
      else $error("joint update missing");
   AST_POWER_DOWN: assert property (
      s_end(MODE_POWER_DOWN) |-> ##[1:6] (pd_active && pd_term == (fw.chan[1] ? TERM_HIZ : fw.chan)))
      else $error("power-down state wrong");
   AST_PD_KEEPS_CODES: assert property (
      s_end(MODE_POWER_DOWN) |-> $stable(out_code) [*8]) else $error("power-down moved codes");
   AST_HOLD_ONLY: assert property (
      fin && (!acc_r || fw.mode == MODE_WRITE_ONLY) |-> ($stable(out_code) && $stable(pd_active)) [*8])
      else $error("holding write moved outputs");
endmodule // quad_dac_sva

bind quad_dac_frame_ctrl quad_dac_sva i_quad_dac_sva (
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
   .hresp, .sclk, .sync_n, .sdin, .out_code, .pd_active, .pd_term
);
`default_nettype wire

// File: testbench/serial_host.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// host end of the three-wire link
// ==========================================
module serial_host (
   output logic sclk,
   output logic sync_n,
   output logic sdin
);
   // clock parked high between frames, never free running
   initial begin
      sclk = 1'b1;
      sync_n = 1'b1;
      sdin = 1'b0;
   end

   // n below 16 aborts the frame, above 16 adds stray edges
   task automatic send(input logic [15:0] w, input int n);
      #3.7;
      sync_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         sdin = (i < 16) ? w[15-i] : 1'($urandom);
         #6;
         sclk = 1'b0;
         #6;
         sclk = 1'b1;
      end
      #6;
      sync_n = 1'b1;
      sdin = ~sdin; // released line must not show a stale bit
   endtask
endmodule // serial_host
`default_nettype wire

// File: testbench/quad_dac_serial_frame_control_test.sv
`timescale 1ns/1ps
`default_nettype none

module quad_dac_serial_frame_control_test
   import dac_frame_pkg::*;
;
   logic                             hclk = 1'b0;
   logic                             hresetn;
   logic                             hsel;
   logic                             hwrite;
   logic [1:0]                       htrans;
   logic [31:0]                      haddr;
   logic [31:0]                      hwdata;
   logic                             hreadyout;
   logic                             hresp;
   logic [31:0]                      hrdata;
   logic                             sclk;
   logic                             sync_n;
   logic                             sdin;
   logic [NUM_CH-1:0][CODE_BITS-1:0] out_code;
   logic                             pd_active;
   logic [1:0]                       pd_term;
   int bad_count = 0;
   int tests_run = 0;
   int hold[4] = '{default: 0};
   int outc[4] = '{default: 0};
   int pd = 0;
   int term = 0;
   int accept = 1;
   int napp = 0;
   int ndrop = 0;
   int last = 0;

   always #12.5 hclk = ~hclk;

   quad_dac_frame_ctrl i_quad_dac_frame_ctrl (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sclk(sclk),
      .sync_n(sync_n), .sdin(sdin), .out_code(out_code), .pd_active(pd_active),
      .pd_term(pd_term)
   );
   serial_host i_serial_host (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));

   // ==========================================
   // checking and bus tasks
   // ==========================================
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // address phase held until hready is seen high, data taken at the next one
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      hsel <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(r, exp);
   endtask

   // ==========================================
   // reference model of a completed frame
   // ==========================================
   task automatic model(input logic [15:0] w);
      int ch;
      int md;
      ch = w[15:14];
      md = w[13:12];
      if (!accept) begin
         ndrop++;
      end else begin
         napp++;
         last = w;
         if (md == MODE_POWER_DOWN) begin
            pd = 1;
            term = (ch > 1) ? 2 : ch;
         end else begin
            hold[ch] = w[11:0];
            if (md == MODE_WRITE_UPDATE) outc[ch] = w[11:0];
            if (md == MODE_UPDATE_ALL) outc = hold;
            if (md != MODE_WRITE_ONLY) pd = 0;
         end
      end
   endtask

   task automatic check_all();
      logic [31:0] r;
      for (int c = 0; c < NUM_CH; c++) begin
         chk(32'(out_code[c]), 32'(outc[c]));
         rd_chk(OFS_CODE0 + 8'(4 * c), 32'(outc[c]));
         rd_chk(OFS_HOLD0 + 8'(4 * c), 32'(hold[c]));
      end
      chk(32'(pd_active), 32'(pd));
      chk(32'(pd_term), pd ? 32'(term) : 32'h0);
      xfer(1'b0, OFS_STATUS, 32'h0, r);
      chk(r, {8'(ndrop), 4'h0, 1'(napp > 0), 2'(pd ? term : 0), 1'(pd), 16'(napp)});
      rd_chk(OFS_LAST, 32'(last));
   endtask

   // output settles on the fifth bus clock edge after the last bit; 8 gives margin
   task automatic frame(input logic [15:0] w, input int n);
      i_serial_host.send(w, n);
      if (n >= FRAME_BITS) model(w);
      repeat (8) @(posedge hclk);
      check_all();
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ==========================================
   // main sequence
   // ==========================================
   initial begin
      logic [31:0] r;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      void'($urandom(91834));
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      check_all();
      rd_chk(OFS_CTRL, 32'(CTRL_RESET));
      rd_chk(8'h40, 32'h0);
      $display("test reset done");
      // short frames change nothing, outputs stay at zero
      for (int n = 1; n < 16; n += 7) frame({2'h1, MODE_WRITE_UPDATE, 12'hfff}, n);
      $display("test abort done");
      // every mode on every channel, some with stray edges after the last bit
      for (int i = 0; i < 16; i++) frame({2'(i / 4), 2'(i % 4), 12'($urandom)}, 16 + i % 3);
      frame({2'h2, MODE_WRITE_UPDATE, 12'($urandom)}, 16);
      $display("test modes done");
      xfer(1'b1, OFS_CTRL, 32'h0, r);
      accept = 0;
      frame({2'h3, MODE_UPDATE_ALL, 12'h5a5}, 16);
      xfer(1'b1, OFS_CTRL, 32'(CTRL_RESET), r);
      accept = 1;
      $display("test drop done");
      // zero request clears holding and output codes alike
      xfer(1'b1, OFS_CTRL, 32'h3, r);
      repeat (8) @(posedge hclk);
      rd_chk(OFS_CTRL, 32'h1);
      hold = '{default: 0};
      outc = '{default: 0};
      check_all();
      frame({2'h1, MODE_UPDATE_ALL, 12'h800}, 16);
      $display("test zero done");
      wrap_up();
   end

   // hang guard, far beyond the expected run length
   initial begin
      #200000;
      bad_count++;
      $display("BAD %0t watchdog expired", $time);
      wrap_up();
   end
endmodule // quad_dac_serial_frame_control_test
`default_nettype wire
